// ===== include/wil_pkg.sv
// Shared constants and types for the weld initiation input logic.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package wil_pkg;

  localparam int CLK_MHZ = 125;

  // Contact debounce time, sequence tick and pressure-wait flash half period.
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int FLASH_US = 250000;
  localparam int FLASH_CYC = FLASH_US * CLK_MHZ;

  // Fixed start schedules of the second and third initiation inputs.
  localparam logic [7:0] SCHED_SECOND = 8'h0A;
  localparam logic [7:0] SCHED_THIRD = 8'h14;
  // First schedule reached by the external two-bit selector.
  localparam logic [7:0] EXT_SCHED_BASE = 8'h01;

  // Register byte addresses.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TIME = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Control register fields.
  localparam int CTRL_EXT_SEL = 0;
  localparam int CTRL_REPEAT = 1;
  localparam int CTRL_TWO_STAGE = 2;
  localparam int CTRL_WELD_MODE = 3;
  localparam int CTRL_SCHED_LSB = 8;
  localparam int CTRL_VALVE_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0007_0108;

  // Interval register fields, each a count of sequence ticks.
  localparam int TIME_SQZ_LSB = 0;
  localparam int TIME_WELD_LSB = 8;
  localparam int TIME_HOLD_LSB = 16;
  localparam logic [31:0] TIME_RST = 32'h0005_0A05;

  // Status register fields.
  localparam int STAT_SW_LSB = 0;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_SCHED_LSB = 16;

  // Debounced contacts, each high when its contact to common is closed.
  typedef struct packed {
    logic first_stage_input;
    logic main_pilot_input;
    logic second_initiate_input;
    logic third_initiate_input;
    logic pressure_ok_input;
    logic stop_chain_input;
    logic weld_enable_input;
    logic over_temperature_input;
  } wil_sw_t;

  typedef struct packed {
    logic valve_one_output;
    logic valve_two_output;
    logic valve_three_output;
    logic fire;
    logic no_weld_led;
    logic squeeze_led;
    logic estop_led;
  } wil_drive_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SQZ = 6'h02,
    ST_PWAIT = 6'h04,
    ST_WELD = 6'h08,
    ST_HOLD = 6'h10,
    ST_STOP = 6'h20
  } wil_state_t;

endpackage

// ===== rtl/wil_debounce.sv
// Per-bit synchroniser and debouncer for dry-contact inputs.
// Assumes raw contacts may bounce; a level must be stable for DB_CYCLES.
module wil_debounce #(
  parameter int N = 8,
  parameter int DB_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] clean
);

  localparam int CW = $clog2(DB_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(DB_CYCLES - 1);

  if (N < 1 || DB_CYCLES < 1)
  begin : g_chk
    $error("wil_debounce: N and DB_CYCLES must be at least one");
  end

  for (genvar i = 0; i < N; i++)
  begin : g_bit
    logic meta_ff;
    logic sync_ff;
    logic [CW-1:0] cnt_ff;
    logic clean_ff;
    wire differs = sync_ff != clean_ff;
    wire settled = differs && cnt_ff == CNT_MAX;

    always_ff @(posedge clk)
    begin
      meta_ff <= raw[i];
      sync_ff <= meta_ff;
    end

    // The counter restarts on every bounce, so a level counts only once stable.
    always_ff @(posedge clk)
    begin
      if (rst || !differs || settled)
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + CW'(1);
    end

    always_ff @(posedge clk)
    begin
      if (rst)
        clean_ff <= 1'b0;
      else if (settled)
        clean_ff <= sync_ff;
    end

    assign clean[i] = clean_ff;
  end

endmodule

// ===== rtl/wil_top.sv
// Weld initiation input logic: contact inputs, start decision, interval
// sequencing, valve and firing gates, and a small register port.
// Assumes contacts are high when closed and a master that never waits.
//
// Contract
// - The third initiation input starts execution at schedule 20.
// - Three single-stage pilots each start their own schedule; the main pilot's is the register-selected one.
// - External select turns second and third inputs into a schedule pointer.
// - In external select the main pilot starts the pointed-to schedule.
// - An open stop chain puts the device into emergency stop.
// - Weld current flows only while the weld-enable contact is closed.
// - There are four initiation inputs: first stage plus three initiators.
// - A single-stage start is latched; the sequence completes if pilot opens.
// - Repeat with single stage restarts while the pilot stays closed.
// - First stage energizes programmed valves and never starts a sequence.
// - Two-stage start begins at the schedule of the closed second stage.
// - After a start, re-initiation is blocked until the sequence completes.
// - Repeat with two stages continues while either stage stays closed.
// - No-weld runs the full sequence without current and lights its lamp.
// - With weld allowed, current passes only in the weld interval.
// - Open weld-enable forces no-weld even if panel selects weld.
// - The second initiation input starts execution at schedule 10.
// - Low pressure after squeeze holds, flashes squeeze, then welds.
// - Open over-temperature contact refuses new initiation until it closes.
// - Stop halts valves and firing; restart needs a new pilot closure.
module wil_top #(
  parameter int DB_CYCLES = wil_pkg::DEBOUNCE_CYC,
  parameter int TICK_CYCLES = wil_pkg::TICK_CYC,
  parameter int FLASH_CYCLES = wil_pkg::FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic first_stage_input,
  input wire logic main_pilot_input,
  input wire logic second_initiate_input,
  input wire logic third_initiate_input,
  input wire logic pressure_ok_input,
  input wire logic stop_chain_input,
  input wire logic weld_enable_input,
  input wire logic over_temperature_input,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output wil_pkg::wil_drive_t drive,
  output logic [7:0] active_sched
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);

  if (TICK_CYCLES < 1 || FLASH_CYCLES < 1 || DB_CYCLES < 1)
  begin : g_chk
    $error("wil_top: cycle counts must be at least one");
  end

  //////////////////////////////////////////////////////////////////////////
  // Contact inputs.

  wil_pkg::wil_sw_t raw_sw;
  wil_pkg::wil_sw_t sw;
  wil_pkg::wil_sw_t sw_prev_ff;
  logic [7:0] sw_clean;

  assign raw_sw = '{
    first_stage_input: first_stage_input,
    main_pilot_input: main_pilot_input,
    second_initiate_input: second_initiate_input,
    third_initiate_input: third_initiate_input,
    pressure_ok_input: pressure_ok_input,
    stop_chain_input: stop_chain_input,
    weld_enable_input: weld_enable_input,
    over_temperature_input: over_temperature_input
  };

  wil_debounce #(
    .N(8),
    .DB_CYCLES(DB_CYCLES)
  ) u_debounce (
    .clk(clk),
    .rst(rst),
    .raw(raw_sw),
    .clean(sw_clean)
  );

  assign sw = wil_pkg::wil_sw_t'(sw_clean);

  always_ff @(posedge clk)
  begin
    if (rst)
      sw_prev_ff <= '0;
    else
      sw_prev_ff <= sw;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0] ctrl_ff;
  logic [31:0] time_ff;
  logic [31:0] nxt_rdata;
  wil_pkg::wil_state_t state_ff;
  wil_pkg::wil_state_t nxt_state;
  logic [7:0] sched_ff;

  wire ext_sel = ctrl_ff[wil_pkg::CTRL_EXT_SEL];
  wire repeat_mode = ctrl_ff[wil_pkg::CTRL_REPEAT];
  wire two_stage = ctrl_ff[wil_pkg::CTRL_TWO_STAGE];
  wire weld_mode = ctrl_ff[wil_pkg::CTRL_WELD_MODE];
  wire [7:0] disp_sched = ctrl_ff[wil_pkg::CTRL_SCHED_LSB +: 8];
  wire [2:0] valve_mask = ctrl_ff[wil_pkg::CTRL_VALVE_LSB +: 3];
  wire [7:0] sqz_len = time_ff[wil_pkg::TIME_SQZ_LSB +: 8];
  wire [7:0] weld_len = time_ff[wil_pkg::TIME_WELD_LSB +: 8];
  wire [7:0] hold_len = time_ff[wil_pkg::TIME_HOLD_LSB +: 8];

  wire wr_ctrl = reg_wr && reg_addr == wil_pkg::ADDR_CTRL;
  wire wr_time = reg_wr && reg_addr == wil_pkg::ADDR_TIME;
  wire [31:0] status_word = {8'h00, sched_ff, 2'b00, state_ff, sw};

  // Unmapped addresses read as zero.
  assign nxt_rdata = !reg_rd ? 32'h0000_0000 :
    reg_addr == wil_pkg::ADDR_CTRL ? ctrl_ff :
    reg_addr == wil_pkg::ADDR_TIME ? time_ff :
    reg_addr == wil_pkg::ADDR_STATUS ? status_word : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= wil_pkg::CTRL_RST;
      time_ff <= wil_pkg::TIME_RST;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= reg_wdata;
      if (wr_time)
        time_ff <= reg_wdata;
      reg_rdata <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Start decision.

  wire rise_main = sw.main_pilot_input && !sw_prev_ff.main_pilot_input;
  wire rise_second = sw.second_initiate_input
    && !sw_prev_ff.second_initiate_input;
  wire rise_third = sw.third_initiate_input
    && !sw_prev_ff.third_initiate_input;
  // In external select the second and third inputs only point, never start.
  wire start_second = rise_second && !ext_sel;
  wire start_third = rise_third && !ext_sel;
  wire healthy = sw.stop_chain_input && sw.over_temperature_input;
  // The first stage is deliberately absent from the start terms.
  wire start_any = rise_main || start_second || start_third;
  wire start_req = start_any && healthy && state_ff == wil_pkg::ST_IDLE;
  wire [1:0] ext_ptr = {sw.third_initiate_input, sw.second_initiate_input};
  wire [7:0] ext_sched = wil_pkg::EXT_SCHED_BASE + {6'h00, ext_ptr};
  wire [7:0] main_sched = ext_sel ? ext_sched : disp_sched;
  wire [7:0] start_sched = rise_main ? main_sched :
    start_second ? wil_pkg::SCHED_SECOND :
    wil_pkg::SCHED_THIRD;
  wire [1:0] start_src = rise_main ? 2'h0 : start_second ? 2'h1 : 2'h2;

  // The input that started the run decides whether repeat continues.
  logic [1:0] src_ff;
  wire src_held = src_ff == 2'h0 ? sw.main_pilot_input :
    src_ff == 2'h1 ? sw.second_initiate_input : sw.third_initiate_input;
  wire held = src_held || (two_stage && sw.first_stage_input);
  wire restart = repeat_mode && held && healthy;

  //////////////////////////////////////////////////////////////////////////
  // Interval timing.

  logic [TW-1:0] tick_cnt_ff;
  logic [7:0] timer_ff;
  logic [7:0] nxt_timer;
  logic load;
  wire tick = tick_cnt_ff == TICK_LAST;
  wire done = tick && timer_ff == 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst || load || tick)
      tick_cnt_ff <= '0;
    else
      tick_cnt_ff <= tick_cnt_ff + TW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      timer_ff <= 8'h00;
    else if (load)
      timer_ff <= nxt_timer;
    else if (tick && timer_ff != 8'h00)
      timer_ff <= timer_ff - 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequence state machine.

  always_comb
  begin
    nxt_state = state_ff;
    nxt_timer = sqz_len;
    load = 1'b0;
    unique case (state_ff)
      wil_pkg::ST_IDLE:
        if (start_req)
        begin
          nxt_state = wil_pkg::ST_SQZ;
          load = 1'b1;
        end
      // Once running, pilot edges are ignored until the run is over.
      wil_pkg::ST_SQZ:
        if (done && sw.pressure_ok_input)
        begin
          nxt_state = wil_pkg::ST_WELD;
          nxt_timer = weld_len;
          load = 1'b1;
        end
        else if (done)
          nxt_state = wil_pkg::ST_PWAIT;
      wil_pkg::ST_PWAIT:
        if (sw.pressure_ok_input)
        begin
          nxt_state = wil_pkg::ST_WELD;
          nxt_timer = weld_len;
          load = 1'b1;
        end
      wil_pkg::ST_WELD:
        if (done)
        begin
          nxt_state = wil_pkg::ST_HOLD;
          nxt_timer = hold_len;
          load = 1'b1;
        end
      wil_pkg::ST_HOLD:
        if (done && restart)
        begin
          nxt_state = wil_pkg::ST_SQZ;
          load = 1'b1;
        end
        else if (done)
          nxt_state = wil_pkg::ST_IDLE;
      wil_pkg::ST_STOP:
        // Leaving to idle still needs a fresh pilot edge to start again.
        if (sw.stop_chain_input)
          nxt_state = wil_pkg::ST_IDLE;
      default:
        nxt_state = wil_pkg::ST_STOP;
    endcase
    if (!sw.stop_chain_input)
    begin
      nxt_state = wil_pkg::ST_STOP;
      load = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= wil_pkg::ST_IDLE;
      sched_ff <= 8'h00;
      src_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (start_req && sw.stop_chain_input)
      begin
        sched_ff <= start_sched;
        src_ff <= start_src;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Valve, firing and lamp drive.

  logic [FW-1:0] flash_cnt_ff;
  logic flash_ff;
  wil_pkg::wil_drive_t nxt_drive;
  wire in_pwait = state_ff == wil_pkg::ST_PWAIT;
  wire running = state_ff != wil_pkg::ST_IDLE
    && state_ff != wil_pkg::ST_STOP;
  wire weld_ok = weld_mode && sw.weld_enable_input;

  always_ff @(posedge clk)
  begin
    if (rst || !in_pwait)
    begin
      flash_cnt_ff <= '0;
      flash_ff <= 1'b0;
    end
    else if (flash_cnt_ff == FLASH_LAST)
    begin
      flash_cnt_ff <= '0;
      flash_ff <= !flash_ff;
    end
    else
      flash_cnt_ff <= flash_cnt_ff + FW'(1);
  end

  // Next-state terms keep the drive one flop from the decision, not two.
  wire nxt_run = nxt_state != wil_pkg::ST_IDLE
    && nxt_state != wil_pkg::ST_STOP;
  wire idle_next = nxt_state == wil_pkg::ST_IDLE;
  wire [2:0] valves = nxt_run ? valve_mask :
    idle_next && sw.first_stage_input ? valve_mask : 3'b000;

  assign nxt_drive = '{
    valve_one_output: valves[0],
    valve_two_output: valves[1],
    valve_three_output: valves[2],
    fire: nxt_state == wil_pkg::ST_WELD && weld_ok,
    no_weld_led: !weld_ok,
    squeeze_led: nxt_state == wil_pkg::ST_SQZ
      || (nxt_state == wil_pkg::ST_PWAIT && !flash_ff),
    estop_led: nxt_state == wil_pkg::ST_STOP
  };

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive <= '0;
      active_sched <= 8'h00;
    end
    else
    begin
      drive <= nxt_drive;
      active_sched <= running ? sched_ff : 8'h00;
    end
  end

endmodule

// ===== verif/wil_switch_model.sv
// Operator, safety and process contacts facing the weld initiation inputs.
// Assumes the bench sets the wanted levels by non-blocking assignment.
module wil_switch_model (
  input wire logic clk,
  input wire wil_pkg::wil_sw_t cmd,
  output wil_pkg::wil_sw_t contacts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_ff;
  logic [7:0] prev_ff;
  // Real contacts bounce, so each change falls back for one cycle
  // before it settles; a debouncer that trusts one sample will fail.
  assign contacts = cmd ^ (last_ff ^ prev_ff);
  always_ff @(posedge clk)
  begin
    last_ff <= cmd;
    prev_ff <= last_ff;
  end
endmodule

// ===== verif/wil_top_sva.sv
// Port-level checker for the weld initiation input logic.
// Assumes raw contacts need about eight cycles to pass the debouncer.
module wil_top_chk #(
  parameter int DB_CYCLES = 4,
  parameter int TICK_CYCLES = 8,
  parameter int FLASH_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic first_stage_input,
  input wire logic main_pilot_input,
  input wire logic second_initiate_input,
  input wire logic third_initiate_input,
  input wire logic pressure_ok_input,
  input wire logic stop_chain_input,
  input wire logic weld_enable_input,
  input wire logic over_temperature_input,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire wil_pkg::wil_drive_t drive,
  input wire logic [7:0] active_sched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_stop_open;
    (!stop_chain_input) [*8];
  endsequence
  sequence s_weld_off;
    (!weld_enable_input) [*8];
  endsequence
  sequence s_temp_open;
    (!over_temperature_input) [*8] ##1 (!over_temperature_input) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_stop_estop: assert property (
    s_stop_open |-> ##[1:6] drive.estop_led)
    else $error("stop chain open without stop state");
  chk_estop_quiet: assert property (
    drive.estop_led |-> !drive.fire && !drive.valve_one_output
      && !drive.valve_two_output && !drive.valve_three_output)
    else $error("valves or firing active in stop");
  chk_fire_allowed: assert property (
    drive.fire |-> !drive.no_weld_led)
    else $error("firing while weld not allowed");
  chk_weld_off_lamp: assert property (
    s_weld_off |-> ##[1:6] drive.no_weld_led)
    else $error("no weld lamp dark with enable open");
  chk_fire_in_run: assert property (
    drive.fire |-> active_sched != 8'h00 && !drive.squeeze_led)
    else $error("firing outside the weld interval");
  chk_start_squeeze: assert property (
    $changed(active_sched) && active_sched != 8'h00 |-> drive.squeeze_led)
    else $error("sequence started without squeeze");
  chk_sched_held: assert property (
    active_sched != 8'h00 |=> active_sched == 8'h00 || $stable(active_sched))
    else $error("schedule changed during a run");
  chk_temp_refuse: assert property (
    s_temp_open ##0 active_sched == 8'h00 |=> active_sched == 8'h00)
    else $error("start accepted with temperature open");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
endmodule
bind wil_top wil_top_chk #(
  .DB_CYCLES(DB_CYCLES),
  .TICK_CYCLES(TICK_CYCLES),
  .FLASH_CYCLES(FLASH_CYCLES)
) u_chk (.clk(clk), .rst(rst), .first_stage_input(first_stage_input),
  .main_pilot_input(main_pilot_input),
  .second_initiate_input(second_initiate_input),
  .third_initiate_input(third_initiate_input),
  .pressure_ok_input(pressure_ok_input),
  .stop_chain_input(stop_chain_input),
  .weld_enable_input(weld_enable_input),
  .over_temperature_input(over_temperature_input), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .drive(drive), .active_sched(active_sched));

// ===== verif/test_wil_top.sv
// Self-checking bench for the weld initiation input logic.
// Assumes short debounce and tick counts; contacts come from the model.
module test_wil_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] rdv;
  wil_pkg::wil_drive_t drive;
  logic [7:0] active_sched;
  wil_pkg::wil_sw_t cmd;
  wil_pkg::wil_sw_t sw;
  logic fire_seen;
  logic flash_prev;
  int cnt;
  int errors;
  int checks;
  wil_switch_model u_sw (.clk(clk), .cmd(cmd), .contacts(sw));
  wil_top #(.DB_CYCLES(4), .TICK_CYCLES(8), .FLASH_CYCLES(4)) uut (
    .clk(clk), .rst(rst), .first_stage_input(sw.first_stage_input),
    .main_pilot_input(sw.main_pilot_input),
    .second_initiate_input(sw.second_initiate_input),
    .third_initiate_input(sw.third_initiate_input),
    .pressure_ok_input(sw.pressure_ok_input),
    .stop_chain_input(sw.stop_chain_input),
    .weld_enable_input(sw.weld_enable_input),
    .over_temperature_input(sw.over_temperature_input),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive(drive),
    .active_sched(active_sched));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk)
    if (drive.fire === 1'b1)
      fire_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask
  // Bounded wait for a run to begin (busy) or to end; a miss shows up
  // in the comparison that follows.
  task automatic wait_sched(input bit busy);
    int n;
    n = 0;
    while (((active_sched !== 8'h00) != busy) && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic press(input int b);
    @(posedge clk);
    cmd[b] <= 1'b1;
    repeat (12) @(posedge clk);
    cmd[b] <= 1'b0;
  endtask
  task automatic run(input int b, input logic [7:0] es, input logic ef);
    fire_seen = 1'b0;
    press(b);
    wait_sched(1'b1);
    chk("start schedule", {24'h0, es}, {24'h0, active_sched});
    wait_sched(1'b0);
    chk("fire seen", {31'h0, ef}, {31'h0, fire_seen});
  endtask
  task automatic count_starts;
    logic prev;
    cnt = 0;
    prev = 1'b0;
    repeat (250)
    begin
      @(negedge clk);
      if (drive.squeeze_led === 1'b1 && prev === 1'b0)
        cnt++;
      prev = drive.squeeze_led;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    cmd = 8'h0F;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fire_seen = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(wil_pkg::ADDR_CTRL);
    chk("ctrl reset", wil_pkg::CTRL_RST, rdv);
    rd(wil_pkg::ADDR_TIME);
    chk("time reset", wil_pkg::TIME_RST, rdv);
    rd(4'hC);
    chk("unmapped read", 32'h0, rdv);
    repeat (20) @(posedge clk);
    wr(wil_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    rd(wil_pkg::ADDR_STATUS);
    chk("status", 32'h0000_010F, {16'h0, rdv[15:0]});
    wr(wil_pkg::ADDR_TIME, 32'h0001_0201);
    wr(wil_pkg::ADDR_CTRL, 32'h0005_0508);
    @(posedge clk);
    cmd.first_stage_input <= 1'b1;
    repeat (15) @(negedge clk);
    chk("stage valves", 32'h5, {29'h0, drive[6:4]});
    chk("stage start", 32'h0, {24'h0, active_sched});
    @(posedge clk);
    cmd.first_stage_input <= 1'b0;
    run(6, 8'h05, 1'b1);
    run(5, wil_pkg::SCHED_SECOND, 1'b1);
    run(4, wil_pkg::SCHED_THIRD, 1'b1);
    @(posedge clk);
    cmd.weld_enable_input <= 1'b0;
    run(6, 8'h05, 1'b0);
    chk("no weld lamp", 32'h1, {31'h0, drive.no_weld_led});
    cmd.weld_enable_input <= 1'b1;
    cmd.over_temperature_input <= 1'b0;
    repeat (12) @(posedge clk);
    run(6, 8'h00, 1'b0);
    cmd.over_temperature_input <= 1'b1;
    repeat (12) @(posedge clk);
    wr(wil_pkg::ADDR_CTRL, 32'h0005_0509);
    run(5, 8'h00, 1'b0);
    cmd.second_initiate_input <= 1'b1;
    run(6, wil_pkg::EXT_SCHED_BASE + 8'h01, 1'b1);
    cmd.second_initiate_input <= 1'b0;
    wr(wil_pkg::ADDR_CTRL, 32'h0005_050C);
    cmd.first_stage_input <= 1'b1;
    run(4, wil_pkg::SCHED_THIRD, 1'b1);
    cmd.first_stage_input <= 1'b0;
    wr(wil_pkg::ADDR_CTRL, 32'h0005_050A);
    cmd.main_pilot_input <= 1'b1;
    count_starts();
    chk("repeat single", 32'h1, {31'h0, cnt >= 2});
    @(posedge clk);
    cmd.main_pilot_input <= 1'b0;
    wait_sched(1'b0);
    wr(wil_pkg::ADDR_CTRL, 32'h0005_050E);
    cmd.first_stage_input <= 1'b1;
    press(6);
    count_starts();
    chk("repeat two stage", 32'h1, {31'h0, cnt >= 2});
    @(posedge clk);
    cmd.first_stage_input <= 1'b0;
    wait_sched(1'b0);
    chk("repeat end", 32'h0, {24'h0, active_sched});
    wr(wil_pkg::ADDR_CTRL, 32'h0005_0508);
    cmd.main_pilot_input <= 1'b1;
    wait_sched(1'b1);
    @(posedge clk);
    cmd.stop_chain_input <= 1'b0;
    repeat (15) @(negedge clk);
    chk("stop lamp", 32'h1, {31'h0, drive.estop_led});
    chk("stop outputs", 32'h0, {28'h0, drive[6:3]});
    @(posedge clk);
    cmd.stop_chain_input <= 1'b1;
    repeat (60) @(negedge clk);
    chk("no restart", 32'h0, {24'h0, active_sched});
    // The pilot must stay open past the debounce time, or no new edge
    // reaches the start logic.
    @(posedge clk);
    cmd.main_pilot_input <= 1'b0;
    cmd.pressure_ok_input <= 1'b0;
    repeat (12) @(posedge clk);
    fire_seen = 1'b0;
    press(6);
    repeat (150) @(negedge clk);
    chk("pressure hold", 32'h2, {30'h0, active_sched !== 8'h00,
        fire_seen});
    flash_prev = drive.squeeze_led;
    repeat (4) @(negedge clk);
    chk("squeeze flash", {31'h0, !flash_prev},
        {31'h0, drive.squeeze_led});
    @(posedge clk);
    cmd.pressure_ok_input <= 1'b1;
    wait_sched(1'b0);
    chk("pressure weld", 32'h1, {31'h0, fire_seen});
    tally_and_finish();
  end
endmodule
